// ==== rtl/splo_pkg.sv ====
// Package: register map, field layout and reset values of the output-stage control bank
package splo_pkg;
  // ----------------------------------------
  // Register indices and bus address width
  // ----------------------------------------
  localparam logic [7:0] SPLO_IDX_MIXER = 8'h07;
  localparam logic [7:0] SPLO_IDX_ANTIPOP = 8'h08;
  localparam logic [7:0] SPLO_IDX_BOOST = 8'h09;
  localparam logic [7:0] SPLO_IDX_SPKMODE = 8'h0a;
  localparam logic [7:0] SPLO_IDX_POWER = 8'h0b;
  localparam logic [7:0] SPLO_IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] SPLO_IDX_IRQ_MASK = 8'h11;
  localparam int SPLO_ADDR_W = 10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SPLO_MIX_IN1_EN = 0;
  localparam int SPLO_MIX_IN1_ATT = 1;
  localparam int SPLO_MIX_IN2_EN = 2;
  localparam int SPLO_MIX_IN2_ATT = 3;
  localparam int SPLO_MIX_CONV_SEL = 4;
  localparam int SPLO_AP_CLAMP = 0;
  localparam int SPLO_AP_RSEL = 1;
  localparam int SPLO_AP_DISCH = 2;
  localparam int SPLO_BST_AC_LSB = 0;
  localparam int SPLO_BST_DC_LSB = 3;
  localparam int SPLO_SM_GUARD_B = 3;
  localparam int SPLO_SM_GUARD_A = 4;
  localparam int SPLO_SM_CLASS = 6;
  localparam int SPLO_PM_CONV = 0;
  localparam int SPLO_PM_SPK = 1;
  localparam int SPLO_PM_AMP = 2;
  localparam int SPLO_PM_LINE = 4;
  localparam int SPLO_PM_TEMP = 6;
  localparam int SPLO_PM_SENSE = 7;
  localparam int SPLO_PM_TSHUT = 8;
  localparam int SPLO_IRQ_OVERTEMP = 0;
  localparam int SPLO_IRQ_TEMP_CLEAR = 1;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [2:0] SPLO_BOOST_RST = 3'h3;
  localparam logic [2:0] SPLO_BOOST_MAX = 3'h5;
  localparam logic [15:0] SPLO_MIXER_WMASK = 16'h001f;
  localparam logic [15:0] SPLO_ANTIPOP_WMASK = 16'h0007;
  localparam logic [15:0] SPLO_SPKMODE_WMASK = 16'h0058;
  localparam logic [15:0] SPLO_POWER_WMASK = 16'h0197;
  localparam logic [15:0] SPLO_SPKMODE_RST = 16'h0018;
  localparam logic [15:0] SPLO_POWER_RST = 16'h0180;
  localparam logic [1:0] SPLO_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPLO_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Controls presented to the analogue stage
  // ----------------------------------------
  typedef struct packed {
    logic       input_one_path_en;
    logic       input_two_path_en;
    logic       input_one_atten;
    logic       input_two_atten;
    logic       converter_path_sel;
    logic       line_output_discharge;
    logic       line_clamp_active;
    logic       line_clamp_resistance_sel;
    logic [2:0] speaker_dc_boost;
    logic [2:0] speaker_ac_boost;
    logic       speaker_class_sel;
    logic       speaker_pop_guard_a;
    logic       speaker_pop_guard_b;
    logic       line_output_en;
    logic       speaker_amp_en;
    logic       speaker_output_en;
    logic       converter_en;
    logic       thermal_sensor_en;
  } splo_ctrl_t;
endpackage

// ==== rtl/splo_regs.sv ====
// Output-stage control register bank behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module splo_regs
  import splo_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic [SPLO_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [SPLO_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   over_temp_pin,
  output splo_ctrl_t                  ctrl,
  output logic                        irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] mixer_reg;
  logic [15:0] antipop_reg;
  logic [2:0]  dc_boost;
  logic [2:0]  ac_boost;
  logic [15:0] spkmode_reg;
  logic [15:0] power_reg;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        ot_meta;
  logic        ot_sync;
  logic        temp_exceeded;
  logic        temp_prev;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic                   aw_held;
  logic                   w_held;
  logic [SPLO_ADDR_W-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic [7:0]             wr_idx;
  logic [15:0]            wr_bits;
  logic                   wr_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx        = aw_addr[SPLO_ADDR_W-1:2];

  // Only the low two byte lanes carry register bits
  always_comb begin
    wr_bits = w_data[15:0];
    wr_hit = (wr_idx == SPLO_IDX_MIXER) || (wr_idx == SPLO_IDX_ANTIPOP) || (wr_idx == SPLO_IDX_BOOST) ||
             (wr_idx == SPLO_IDX_SPKMODE) || (wr_idx == SPLO_IDX_POWER) ||
             (wr_idx == SPLO_IDX_IRQ_STAT) || (wr_idx == SPLO_IDX_IRQ_MASK);
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [3:0] strb,
                                        input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lane) | (nw & lane);
  endfunction

  // Address and data may come in either order; each is parked until both are in
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SPLO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? SPLO_RESP_OKAY : SPLO_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mixer_reg   <= 16'h0000;
      antipop_reg <= 16'h0000;
      spkmode_reg <= SPLO_SPKMODE_RST;
      power_reg   <= SPLO_POWER_RST;
    end else if (wr_fire) begin
      case (wr_idx)
        SPLO_IDX_MIXER: begin
          mixer_reg <= merge(mixer_reg, wr_bits, w_strb, SPLO_MIXER_WMASK);
        end
        SPLO_IDX_ANTIPOP: begin
          antipop_reg <= merge(antipop_reg, wr_bits, w_strb, SPLO_ANTIPOP_WMASK);
        end
        SPLO_IDX_SPKMODE: begin
          spkmode_reg <= merge(spkmode_reg, wr_bits, w_strb, SPLO_SPKMODE_WMASK);
        end
        SPLO_IDX_POWER: begin
          // Status bit is outside the write mask
          power_reg <= merge(power_reg, wr_bits, w_strb, SPLO_POWER_WMASK);
        end
        default: begin
        end
      endcase
    end
  end

  // Reserved boost codes are held off: a write of 110 or 111 leaves the field as it was
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dc_boost <= SPLO_BOOST_RST;
      ac_boost <= SPLO_BOOST_RST;
    end else if (wr_fire && wr_idx == SPLO_IDX_BOOST && w_strb[0]) begin
      if (wr_bits[SPLO_BST_DC_LSB +: 3] <= SPLO_BOOST_MAX) begin
        dc_boost <= wr_bits[SPLO_BST_DC_LSB +: 3];
      end
      if (wr_bits[SPLO_BST_AC_LSB +: 3] <= SPLO_BOOST_MAX) begin
        ac_boost <= wr_bits[SPLO_BST_AC_LSB +: 3];
      end
    end
  end

  // ----------------------------------------
  // Temperature sensing and events
  // ----------------------------------------
  // The pin is asynchronous: two flops before anything reads it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ot_meta <= 1'b0;
      ot_sync <= 1'b0;
    end else begin
      ot_meta <= over_temp_pin;
      ot_sync <= ot_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      temp_exceeded <= 1'b0;
      temp_prev     <= 1'b0;
    end else begin
      // Sensor off means no reading can be trusted
      temp_exceeded <= ot_sync && power_reg[SPLO_PM_SENSE];
      temp_prev     <= temp_exceeded;
    end
  end

  logic       rd_stat;
  logic [1:0] irq_event;
  assign irq_event[SPLO_IRQ_OVERTEMP]   = temp_exceeded && !temp_prev;
  assign irq_event[SPLO_IRQ_TEMP_CLEAR] = !temp_exceeded && temp_prev;

  // Set wins over the read-clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (rd_stat ? 2'h0 : irq_stat) | irq_event;
    end
  end

  // Mask takes lane 0 only; writes to the status register are ignored
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_mask <= 2'h0;
    end else if (wr_fire && wr_idx == SPLO_IDX_IRQ_MASK && w_strb[0]) begin
      irq_mask <= wr_bits[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [7:0]  rd_idx;
  logic [15:0] rd_val;
  logic        rd_hit;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[SPLO_ADDR_W-1:2];
  // Status clears on acceptance; a slow rready cannot swallow a later set
  assign rd_stat       = s_axi_arvalid && s_axi_arready && rd_idx == SPLO_IDX_IRQ_STAT;

  always_comb begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;
    case (rd_idx)
      SPLO_IDX_MIXER:    rd_val = mixer_reg;
      SPLO_IDX_ANTIPOP:  rd_val = antipop_reg;
      SPLO_IDX_BOOST:    rd_val = {10'h000, dc_boost, ac_boost};
      SPLO_IDX_SPKMODE:  rd_val = spkmode_reg;
      SPLO_IDX_POWER: begin
        rd_val = power_reg;
        rd_val[SPLO_PM_TEMP] = temp_exceeded;
      end
      SPLO_IDX_IRQ_STAT: rd_val = {14'h0, irq_stat};
      SPLO_IDX_IRQ_MASK: rd_val = {14'h0, irq_mask};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= SPLO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? SPLO_RESP_OKAY : SPLO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Analogue controls, registered
  // ----------------------------------------
  logic shutdown;
  logic clamp_on;
  assign shutdown = power_reg[SPLO_PM_TSHUT] && temp_exceeded;
  // Clamp only while line output is off; buffer enable is software's duty
  assign clamp_on = antipop_reg[SPLO_AP_CLAMP] && !power_reg[SPLO_PM_LINE];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl <= '0;
      ctrl.speaker_dc_boost    <= SPLO_BOOST_RST;
      ctrl.speaker_ac_boost    <= SPLO_BOOST_RST;
      ctrl.speaker_pop_guard_a <= 1'b1;
      ctrl.speaker_pop_guard_b <= 1'b1;
      ctrl.thermal_sensor_en   <= 1'b1;
    end else begin
      ctrl.input_one_path_en  <= mixer_reg[SPLO_MIX_IN1_EN];
      ctrl.input_two_path_en  <= mixer_reg[SPLO_MIX_IN2_EN];
      ctrl.input_one_atten    <= mixer_reg[SPLO_MIX_IN1_ATT];
      ctrl.input_two_atten    <= mixer_reg[SPLO_MIX_IN2_ATT];
      ctrl.converter_path_sel <= mixer_reg[SPLO_MIX_CONV_SEL];
      ctrl.line_output_discharge <= antipop_reg[SPLO_AP_DISCH];
      ctrl.line_clamp_active         <= clamp_on;
      ctrl.line_clamp_resistance_sel <= antipop_reg[SPLO_AP_RSEL] && clamp_on;
      ctrl.speaker_dc_boost  <= dc_boost;
      ctrl.speaker_ac_boost  <= ac_boost;
      ctrl.speaker_class_sel <= spkmode_reg[SPLO_SM_CLASS];
      if (!spkmode_reg[SPLO_SM_CLASS]) begin
        // Class D: guards follow the output enable
        ctrl.speaker_pop_guard_a <= !power_reg[SPLO_PM_SPK];
        ctrl.speaker_pop_guard_b <= !power_reg[SPLO_PM_SPK];
      end else begin
        ctrl.speaker_pop_guard_a <= spkmode_reg[SPLO_SM_GUARD_A];
        ctrl.speaker_pop_guard_b <= spkmode_reg[SPLO_SM_GUARD_B];
      end
      ctrl.line_output_en    <= power_reg[SPLO_PM_LINE] && !shutdown;
      ctrl.speaker_amp_en    <= power_reg[SPLO_PM_AMP] && !shutdown;
      ctrl.speaker_output_en <= power_reg[SPLO_PM_SPK] && !shutdown;
      ctrl.converter_en      <= power_reg[SPLO_PM_CONV];
      ctrl.thermal_sensor_en <= power_reg[SPLO_PM_SENSE];
    end
  end

endmodule

// ==== bench/splo_regs_assertions.sv ====
// Port-level checks for the output-stage control register bank
`timescale 1ns/10ps
module splo_regs_assertions
  import splo_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire splo_ctrl_t ctrl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Analogue controls
  // ----------------------------------------
  dc_boost_legal_a:
    assert property (ctrl.speaker_dc_boost <= SPLO_BOOST_MAX)
    else $error("dc boost holds a reserved code");
  ac_boost_legal_a:
    assert property (ctrl.speaker_ac_boost <= SPLO_BOOST_MAX)
    else $error("ac boost holds a reserved code");
  clamp_rsel_a:
    assert property (ctrl.line_clamp_resistance_sel |-> ctrl.line_clamp_active)
    else $error("clamp resistance selected without clamp");
  clamp_line_off_a:
    assert property (ctrl.line_clamp_active |-> !ctrl.line_output_en)
    else $error("clamp active with line output on");
  classd_guard_a:
    assert property (!ctrl.speaker_class_sel && ctrl.speaker_output_en |-> !ctrl.speaker_pop_guard_a && !ctrl.speaker_pop_guard_b)
    else $error("class d guards not released by speaker enable");
  guard_pair_a:
    assert property (!ctrl.speaker_class_sel |-> ctrl.speaker_pop_guard_a == ctrl.speaker_pop_guard_b)
    else $error("class d guards disagree");
  // Reset itself is the cause here, so it cannot also disable the check
  reset_values_a:
    assert property (disable iff (1'b0) !rstn |=> ctrl.speaker_dc_boost == SPLO_BOOST_RST
      && ctrl.speaker_ac_boost == SPLO_BOOST_RST && ctrl.speaker_pop_guard_a && ctrl.speaker_pop_guard_b
      && ctrl.thermal_sensor_en && !ctrl.line_output_en && !ctrl.speaker_output_en && !ctrl.converter_en)
    else $error("control outputs wrong after reset");

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  write_refused_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_refused_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the output-stage control register bank
`timescale 1ns/10ps
module testbench;
  import splo_pkg::*;
  typedef struct packed {
    logic [9:0]  addr;
    logic [15:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } splo_row_t;

  localparam logic [9:0] adr_ap = 10'h020;
  localparam logic [9:0] adr_spk = 10'h028;
  localparam logic [9:0] adr_pwr = 10'h02c;
  localparam logic [9:0] adr_stat = 10'h040;

  logic                   sys_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   over_temp_pin = 1'b0;
  logic [SPLO_ADDR_W-1:0] s_axi_awaddr = 10'h000;
  logic [SPLO_ADDR_W-1:0] s_axi_araddr = 10'h000;
  logic [31:0]            s_axi_wdata = 32'h0;
  logic [3:0]             s_axi_wstrb = 4'hf;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic [31:0]            s_axi_rdata;
  splo_ctrl_t             ctrl;
  logic [3:0]             out_state;
  int                     n_errors = 0;
  int                     n_tests = 0;

  // Reserved boost codes leave only that field untouched
  splo_row_t rows [9] = '{
    '{10'h01c, 16'hffff, 32'h0000001f, SPLO_RESP_OKAY},
    '{10'h020, 16'h0005, 32'h00000005, SPLO_RESP_OKAY},
    '{10'h024, 16'h0015, 32'h00000015, SPLO_RESP_OKAY},
    '{10'h024, 16'h0031, 32'h00000011, SPLO_RESP_OKAY},
    '{10'h024, 16'h002e, 32'h00000029, SPLO_RESP_OKAY},
    '{10'h028, 16'hffff, 32'h00000058, SPLO_RESP_OKAY},
    '{10'h02c, 16'h0040, 32'h00000000, SPLO_RESP_OKAY},
    '{10'h03c, 16'hffff, 32'h00000000, SPLO_RESP_SLVERR},
    '{10'h044, 16'h0001, 32'h00000001, SPLO_RESP_OKAY}
  };

  assign out_state = {ctrl.line_output_en, ctrl.speaker_amp_en, ctrl.speaker_output_en, irq};

  splo_regs uut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .over_temp_pin, .ctrl, .irq);

  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ends two edges after the response so ctrl has picked up the write
  task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
    chk(s_axi_rdata, ed);
  endtask

  task automatic reset_check();
    rd(10'h01c, 32'h0, SPLO_RESP_OKAY);
    rd(adr_ap, 32'h0, SPLO_RESP_OKAY);
    rd(10'h024, 32'h1b, SPLO_RESP_OKAY);
    rd(adr_spk, 32'h18, SPLO_RESP_OKAY);
    rd(adr_pwr, 32'h180, SPLO_RESP_OKAY);
    // Boosts 3, both guards and sensor on, irq low
    chk({9'h0, ctrl, irq}, 32'h000036c2);
  endtask

  task automatic complete_run();
    $display("Tests %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    reset_check();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].resp);
      rd(rows[i].addr, rows[i].rdata, rows[i].resp);
    end
    chk({10'h0, ctrl}, 32'h003fa9e0);
    wr(adr_spk, 16'h0040, SPLO_RESP_OKAY);
    wr(adr_pwr, 16'h0182, SPLO_RESP_OKAY);
    chk({29'h0, ctrl.speaker_pop_guard_a, ctrl.speaker_pop_guard_b, ctrl.speaker_output_en}, 32'h1);
    wr(adr_spk, 16'h0018, SPLO_RESP_OKAY);
    chk({29'h0, ctrl.speaker_pop_guard_a, ctrl.speaker_pop_guard_b, ctrl.speaker_output_en}, 32'h1);
    wr(adr_pwr, 16'h0180, SPLO_RESP_OKAY);
    chk({29'h0, ctrl.speaker_pop_guard_a, ctrl.speaker_pop_guard_b, ctrl.speaker_output_en}, 32'h6);
    wr(adr_ap, 16'h0003, SPLO_RESP_OKAY);
    chk({29'h0, ctrl.line_clamp_active, ctrl.line_clamp_resistance_sel, ctrl.line_output_discharge}, 32'h6);
    wr(adr_pwr, 16'h0190, SPLO_RESP_OKAY);
    chk({29'h0, ctrl.line_clamp_active, ctrl.line_clamp_resistance_sel, ctrl.line_output_en}, 32'h1);
    // Hot with the sensor off: no status, outputs stay on
    wr(adr_pwr, 16'h0116, SPLO_RESP_OKAY);
    over_temp_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(adr_pwr, 32'h116, SPLO_RESP_OKAY);
    chk({28'h0, out_state}, 32'he);
    wr(adr_pwr, 16'h0096, SPLO_RESP_OKAY);
    repeat (6) @(posedge sys_clk);
    rd(adr_pwr, 32'h0d6, SPLO_RESP_OKAY);
    chk({28'h0, out_state}, 32'hf);
    wr(adr_pwr, 16'h0196, SPLO_RESP_OKAY);
    rd(adr_pwr, 32'h1d6, SPLO_RESP_OKAY);
    chk({28'h0, out_state}, 32'h1);
    rd(adr_stat, 32'h1, SPLO_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    over_temp_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(adr_pwr, 32'h196, SPLO_RESP_OKAY);
    chk({28'h0, out_state}, 32'he);
    rd(adr_stat, 32'h2, SPLO_RESP_OKAY);
    // Lane 1 only: the shutdown enable clears, lane 0 bits stay
    s_axi_wstrb <= 4'h2;
    wr(adr_pwr, 16'h00ff, SPLO_RESP_OKAY);
    rd(adr_pwr, 32'h096, SPLO_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    wr(adr_pwr, 16'h0181, SPLO_RESP_OKAY);
    chk({31'h0, ctrl.converter_en}, 32'h1);
    rstn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    reset_check();
    complete_run();
  end
endmodule

bind splo_regs splo_regs_assertions chk_i (.sys_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ctrl);
